/* File: rtl/pmd_top.sv */
// The register addresses and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
// How it works
// - first register bits 15..11 stop timers 5..1; zero runs them
// - first register bit 10 stops quadrature decoder, bit 9 motor pwm
// - first register bits 7..4 stop i2c one, uart two, uart one, spi two
// - first register bits 3..0 stop spi one, can two, can one, adc one
// - a stopped converter drops its analog claim; a shared pin goes digital unless the other converter runs and selects it analog
// - second register bits 15..8 stop input captures 8..1
// - second register bits 7..0 stop output compares 8..1
// - third register bits 15..12 stop timers 9..6
// - third register bit 1 stops i2c two, bit 0 adc two
// - unimplemented bits read zero and ignore writes
// - implemented bits are read/write and clear at reset
// - a change reaches the peripheral one instruction cycle after the write
// - a stopped peripheral must refuse register writes; its reads are invalid
// - a peripheral runs only if its bit is clear and it exists
module pmd_top
  import pmd_pkg::*;
#(
  parameter int          NPIN         = 32,
  parameter int          INSTR_DLY    = INSTR_CLKS,
  parameter logic [47:0] PRESENT_MASK = {THREE_MASK, TWO_MASK, ONE_MASK}
) (
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [NPIN-1:0]   analog_pin_select_bits_first,
  input  wire logic [NPIN-1:0]   analog_pin_select_bits_second,
  output logic      [NPIN-1:0]   analog_input_pins_digital,
  output logic [NUM_SLOTS-1:0]   periph_run,
  output logic [NUM_SLOTS-1:0]   periph_clk
);

  // ==========================================================
  // bus decode
  logic [REG_W-1:0]     one_q;
  logic [REG_W-1:0]     two_q;
  logic [REG_W-1:0]     three_q;
  logic [REG_W-1:0]     one_d;
  logic [REG_W-1:0]     two_d;
  logic [REG_W-1:0]     three_d;
  logic                 pready_q;
  logic                 pslverr_q;
  logic [31:0]          prdata_q;
  logic [DLY_W-1:0]     dly_q;
  logic                 pend_q;
  logic [NUM_SLOTS-1:0] run_q;
  logic [NUM_SLOTS-1:0] off_req;
  logic [NPIN-1:0]      digital_q;

  wire hit_one   = (paddr == ONE_OFF);
  wire hit_two   = (paddr == TWO_OFF);
  wire hit_three = (paddr == THREE_OFF);
  wire hit_any   = hit_one | hit_two | hit_three;

  // setup cycle: answer is prepared here so every bus output is a flop
  wire setup_cyc = psel & ~penable;
  // access cycle with ready high: the only edge at which a write lands
  wire acc_done  = psel & penable & pready_q;
  wire wr_fire   = acc_done & pwrite & hit_any;

  // ==========================================================
  // byte-lane merge of write data
  wire [REG_W-1:0] lane_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
  wire [REG_W-1:0] wdata16   = pwdata[REG_W-1:0];

  // only implemented bits ever take new data
  wire [REG_W-1:0] one_wr   = (one_q & ~lane_mask) | (wdata16 & lane_mask);
  wire [REG_W-1:0] two_wr   = (two_q & ~lane_mask) | (wdata16 & lane_mask);
  wire [REG_W-1:0] three_wr = (three_q & ~lane_mask) | (wdata16 & lane_mask);

  assign one_d   = (wr_fire & hit_one) ? (one_wr & ONE_MASK) : one_q;
  assign two_d   = (wr_fire & hit_two) ? (two_wr & TWO_MASK) : two_q;
  assign three_d = (wr_fire & hit_three) ? (three_wr & THREE_MASK) : three_q;

  // ==========================================================
  // read mux; unmapped addresses read zero and flag an error
  wire [REG_W-1:0] rd_sel =
    hit_one   ? (one_q & ONE_MASK)     :
    hit_two   ? (two_q & TWO_MASK)     :
    hit_three ? (three_q & THREE_MASK) : REG_RST;

  wire [31:0] rd_word = {16'h0000, rd_sel};

  // ==========================================================
  // software copy of the disable registers
  // readback shows the new value at once; the peripherals follow later
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      one_q   <= REG_RST;
      two_q   <= REG_RST;
      three_q <= REG_RST;
    end
    else
    begin
      one_q   <= one_d;
      two_q   <= two_d;
      three_q <= three_d;
    end
  end

  // ==========================================================
  // apb answer: one wait-free access cycle after every setup cycle
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end
    else
    begin
      pready_q  <= setup_cyc;
      pslverr_q <= setup_cyc & ~hit_any;
      prdata_q  <= (setup_cyc & ~pwrite) ? rd_word : 32'h0000_0000;
    end
  end

  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign prdata  = prdata_q;

  // ==========================================================
  // field assembly into the flat slot vector
  // each slot is one peripheral; slot = register base + bit position
  always_comb
  begin
    off_req = '0;
    // timers 5..1 sit on bits 15..11 of the first register
    for (int t = TIMER1_POS; t <= TIMER5_POS; t++)
    begin
      off_req[ONE_BASE + t] = one_q[t];
    end
    // motor control blocks
    off_req[ONE_BASE + QUAD_DEC_POS]  = one_q[QUAD_DEC_POS];
    off_req[ONE_BASE + MOTOR_PWM_POS] = one_q[MOTOR_PWM_POS];
    // serial blocks: i2c one, uart two, uart one, spi two
    for (int s = SPI_SECOND_POS; s <= I2C_FIRST_POS; s++)
    begin
      off_req[ONE_BASE + s] = one_q[s];
    end
    // spi one, can two, can one, adc one
    for (int c = ADC_FIRST_POS; c <= SPI_FIRST_POS; c++)
    begin
      off_req[ONE_BASE + c] = one_q[c];
    end
    // input captures 8..1 on bits 15..8
    for (int i = CAPTURE1_POS; i < REG_W; i++)
    begin
      off_req[TWO_BASE + i] = two_q[i];
    end
    // output compares 8..1 on bits 7..0
    for (int o = COMPARE1_POS; o < CAPTURE1_POS; o++)
    begin
      off_req[TWO_BASE + o] = two_q[o];
    end
    // timers 9..6 on bits 15..12
    for (int u = TIMER6_POS; u < REG_W; u++)
    begin
      off_req[THREE_BASE + u] = three_q[u];
    end
    off_req[THREE_BASE + I2C_SECOND_POS] = three_q[I2C_SECOND_POS];
    off_req[THREE_BASE + ADC_SECOND_POS] = three_q[ADC_SECOND_POS];
  end

  // a slot runs only if its bit is clear and the block exists
  wire [NUM_SLOTS-1:0] run_req = ~off_req & PRESENT_MASK;

  // ==========================================================
  // one instruction cycle of latency between write and effect
  // a second write while pending restarts the wait; the newest value wins
  wire            dly_load = wr_fire;
  wire            dly_exp  = pend_q & (dly_q == DLY_W'(1));
  wire [DLY_W-1:0] dly_d   = dly_load ? DLY_W'(INSTR_DLY) :
                             pend_q   ? dly_q - DLY_W'(1)  : dly_q;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      dly_q  <= '0;
      pend_q <= 1'b0;
    end
    else
    begin
      dly_q  <= dly_d;
      pend_q <= dly_load | (pend_q & ~dly_exp);
    end
  end

  // ==========================================================
  // run vector: starts with every present block running
  // peripherals use it to block their own register writes
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      run_q <= PRESENT_MASK;
    else if (dly_exp)
      run_q <= run_req;
  end

  assign periph_run = run_q;

  // ==========================================================
  // clock gates
  pmd_ctl_if #(
    .N    (NUM_SLOTS),
    .NPIN (NPIN)
  ) ctl ();

  assign ctl.run = run_q;

  pmd_clk_gate #(
    .N (NUM_SLOTS)
  ) u_gate (
    .sys_clk (sys_clk),
    .rst     (rst),
    .ctl     (ctl.gate)
  );

  // gated clocks cannot come from a data flop; they leave through the gate cells
  assign periph_clk = ctl.gclk;

  // ==========================================================
  // shared analog pins
  // converter off flags follow the same delayed run vector as the clocks
  assign ctl.adc_off[0]  = ~run_q[ONE_BASE + ADC_FIRST_POS];
  assign ctl.adc_off[1]  = ~run_q[THREE_BASE + ADC_SECOND_POS];
  assign ctl.sel_first   = analog_pin_select_bits_first;
  assign ctl.sel_second  = analog_pin_select_bits_second;

  pmd_pin_mode #(
    .NPIN (NPIN)
  ) u_pins (
    .ctl (ctl.pins)
  );

  // registered so the pin mux sees a clean level; reset leaves pins analog
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      digital_q <= '0;
    else
      digital_q <= ctl.digital;
  end

  assign analog_input_pins_digital = digital_q;

endmodule : pmd_top

/* File: common/pmd_pkg.sv */
// ==========================================================
// peripheral disable constants
package pmd_pkg;
  // ==========================================================
  // register map and widths
  localparam int          REG_W     = 16;
  localparam int          ADDR_W    = 12;
  localparam int          NUM_SLOTS = 48;
  localparam logic [11:0] ONE_OFF   = 12'h000;
  localparam logic [11:0] TWO_OFF   = 12'h004;
  localparam logic [11:0] THREE_OFF = 12'h008;
  // implemented bit masks; zero bits read as zero and ignore writes
  localparam logic [15:0] ONE_MASK   = 16'hfeff;
  localparam logic [15:0] TWO_MASK   = 16'hffff;
  localparam logic [15:0] THREE_MASK = 16'hf003;
  localparam logic [15:0] REG_RST    = 16'h0000;
  // base of each register inside the flat slot vector
  localparam int ONE_BASE   = 0;
  localparam int TWO_BASE   = 16;
  localparam int THREE_BASE = 32;
  // ==========================================================
  // field positions
  localparam int TIMER1_POS     = 11;
  localparam int TIMER5_POS     = 15;
  localparam int QUAD_DEC_POS   = 10;
  localparam int MOTOR_PWM_POS  = 9;
  localparam int I2C_FIRST_POS  = 7;
  localparam int SPI_SECOND_POS = 4;
  localparam int SPI_FIRST_POS  = 3;
  localparam int ADC_FIRST_POS  = 0;
  localparam int CAPTURE1_POS   = 8;
  localparam int COMPARE1_POS   = 0;
  localparam int TIMER6_POS     = 12;
  localparam int I2C_SECOND_POS = 1;
  localparam int ADC_SECOND_POS = 0;
  // ==========================================================
  // timing: disable changes land one instruction cycle after the write
  localparam int CLK_PERIOD_NS  = 4;
  localparam int INSTR_CYCLE_NS = 8;
  localparam int INSTR_CLKS     = (INSTR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DLY_W          = 8;
endpackage : pmd_pkg

/* File: common/pmd_ctl_if.sv */
`timescale 1ns/1ps
// ==========================================================
// carrier between the register core, the gates and the pin logic
interface pmd_ctl_if #(
  parameter int N    = 48,
  parameter int NPIN = 32
);
  logic [N-1:0]    run;
  logic [N-1:0]    gclk;
  logic [1:0]      adc_off;
  logic [NPIN-1:0] sel_first;
  logic [NPIN-1:0] sel_second;
  logic [NPIN-1:0] digital;

  modport gate     (input run, output gclk);
  modport core_gate(output run, input gclk);
  modport pins     (input adc_off, sel_first, sel_second, output digital);
  modport core_pins(output adc_off, sel_first, sel_second, input digital);
endinterface : pmd_ctl_if

/* File: rtl/pmd_clk_gate.sv */
`timescale 1ns/1ps
// ==========================================================
// glitch-free clock gates, one per peripheral slot
module pmd_clk_gate #(
  parameter int N = 48
) (
  input wire logic   sys_clk,
  input wire logic   rst,
  pmd_ctl_if.gate    ctl
);
  logic [N-1:0] en_low_q;

  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : gen_gate
      // enable moves only while the clock is low, so no runt pulse escapes
      always_ff @(negedge sys_clk)
      begin
        if (rst)
          en_low_q[g] <= 1'b0;
        else
          en_low_q[g] <= ctl.run[g];
      end
      assign ctl.gclk[g] = sys_clk & en_low_q[g];
    end
  endgenerate
endmodule : pmd_clk_gate

/* File: rtl/pmd_pin_mode.sv */
`timescale 1ns/1ps
// ==========================================================
// analog or digital mode of the pins shared with the converters
module pmd_pin_mode #(
  parameter int NPIN = 32
) (
  pmd_ctl_if.pins ctl
);
  genvar p;
  generate
    for (p = 0; p < NPIN; p++)
    begin : gen_pin
      // a select bit of zero asks for analog, but only a running converter may claim the pin
      wire an_first  = ~ctl.sel_first[p] & ~ctl.adc_off[0];
      wire an_second = ~ctl.sel_second[p] & ~ctl.adc_off[1];
      assign ctl.digital[p] = ~(an_first | an_second);
    end
  endgenerate
endmodule : pmd_pin_mode

/* File: tb/pmd_monitor.sv */
`timescale 1ns/1ps
// ====
// port checks
module pmd_monitor
  import pmd_pkg::*;
#(
  parameter int          NPIN         = 32,
  parameter int          INSTR_DLY    = INSTR_CLKS,
  parameter logic [47:0] PRESENT_MASK = {THREE_MASK, TWO_MASK, ONE_MASK}
) (
  input wire logic              sys_clk,
  input wire logic              rst,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [31:0]       pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic [NPIN-1:0]   analog_pin_select_bits_first,
  input wire logic [NPIN-1:0]   analog_pin_select_bits_second,
  input wire logic [NPIN-1:0]   analog_input_pins_digital,
  input wire logic [47:0]       periph_run
);
  // bus phase decode
  wire setup  = psel & ~penable;
  wire hit    = (paddr == ONE_OFF) | (paddr == TWO_OFF) | (paddr == THREE_OFF);
  wire rd_ok  = pready & ~pwrite;
  wire wr_one = pready & pwrite & pstrb[0] & (paddr == ONE_OFF);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_ready_after:
    assert property (setup |=> pready) else $error("no ready after setup");
  a_ready_pulse:
    assert property (pready |=> !pready) else $error("ready held too long");
  a_err_unmapped:
    assert property (setup && !hit |=> pslverr) else $error("no error on bad address");
  a_idle_zero:
    assert property (!pready |-> prdata == 32'h0) else $error("read data outside access");
  a_upper_zero:
    assert property (pready |-> prdata[31:16] == 16'h0) else $error("upper read bits set");
  a_reserved_zero:
    assert property (rd_ok |-> (paddr != ONE_OFF || !prdata[8])
      && (paddr != THREE_OFF || prdata[11:2] == 10'h0)) else $error("reserved bit set");
  a_run_present:
    assert property ((periph_run & ~PRESENT_MASK) == 48'h0) else $error("absent slot runs");
  // the run flop loads at the write edge plus the delay, so it is first seen one edge later
  a_run_delay:
    assert property (wr_one |-> ##(INSTR_DLY + 1)
      periph_run[0] == (~$past(pwdata[0], INSTR_DLY + 1) & PRESENT_MASK[0]))
      else $error("run change late or early");
  // the pin flop holds its reset value in the first cycle after reset
  a_pin_mode:
    assert property (!$past(rst) |-> analog_input_pins_digital == ~(
      (~$past(analog_pin_select_bits_first) & {NPIN{$past(periph_run[0])}}) |
      (~$past(analog_pin_select_bits_second) & {NPIN{$past(periph_run[32])}})))
      else $error("pin mode wrong");
endmodule : pmd_monitor

bind pmd_top pmd_monitor #(
  .NPIN(NPIN), .INSTR_DLY(INSTR_DLY), .PRESENT_MASK(PRESENT_MASK)
) u_mon (
  .sys_clk, .rst, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .prdata, .pready,
  .pslverr, .analog_pin_select_bits_first, .analog_pin_select_bits_second,
  .analog_input_pins_digital, .periph_run
);

/* File: tb/pmd_periph_model.sv */
`timescale 1ns/1ps
// ====
// peripherals behind the gates
module pmd_periph_model #(
  parameter int N = 48
) (
  input  wire logic [N-1:0] periph_clk,
  output logic      [7:0]   ticks [N]
);
  // state moves only on the gated clock, so a stopped unit freezes
  for (genvar g = 0; g < N; g++)
  begin : g_slot
    initial ticks[g] = 8'h00;
    always @(posedge periph_clk[g])
      ticks[g] <= ticks[g] + 8'h01;
  end
endmodule : pmd_periph_model

/* File: tb/pmd_top_test.sv */
`timescale 1ns/1ps
// ====
// bench
module pmd_top_test
  import pmd_pkg::*;
;
  localparam logic [47:0] PRES = {THREE_MASK, TWO_MASK, ONE_MASK};
  logic              sys_clk = 1'b0;
  logic              rst     = 1'b1;
  logic [ADDR_W-1:0] paddr   = '0;
  logic              psel    = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite  = 1'b0;
  logic [31:0]       pwdata  = '0;
  logic [3:0]        pstrb   = '0;
  logic [31:0]       sel1    = '0;
  logic [31:0]       sel2    = '0;
  logic [31:0]       prdata, digital;
  logic              pready, pslverr;
  logic [47:0]       run, pclk;
  logic [7:0]        ticks [48];
  logic [11:0]       offs [3] = '{ONE_OFF, TWO_OFF, THREE_OFF};
  logic [15:0]       msks [3] = '{ONE_MASK, TWO_MASK, THREE_MASK};
  int                n_mismatch  = 0;
  int                comparisons = 0;
  // 4 ns clock
  always #2 sys_clk = ~sys_clk;
  pmd_top i_dut (
    .sys_clk, .rst, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .prdata, .pready,
    .pslverr, .analog_pin_select_bits_first(sel1), .analog_pin_select_bits_second(sel2),
    .analog_input_pins_digital(digital), .periph_run(run), .periph_clk(pclk)
  );
  pmd_periph_model i_model (.periph_clk(pclk), .ticks(ticks));
  // ====
  // shared tasks
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : wrap_up
  task automatic chk(input string nm, input logic [63:0] x, input logic [63:0] got);
    comparisons++;
    if (got !== x)
    begin
      $display("BAD %s expected %h seen %h", nm, x, got);
      n_mismatch++;
    end
  endtask : chk
  // one transfer; called on a rising edge, returns one edge after release
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] r, output logic e);
    int k;
    k = 0;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    pstrb  <= s;
    @(posedge sys_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (k >= 16)
    begin
      $display("BAD pready expected 1 seen 0");
      n_mismatch++;
      wrap_up();
    end
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, s, r, e);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [15:0] x, input logic er);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, 4'h0, r, e);
    chk("prdata", {48'h0, x}, {32'h0, r});
    chk("pslverr", {63'h0, er}, {63'h0, e});
  endtask : rd
  task automatic pin_step(input logic [11:0] a, input logic [31:0] d, input logic [31:0] x);
    wr(a, d, 4'h3);
    repeat (3) @(posedge sys_clk);
    chk("digital", {32'h0, x}, {32'h0, digital});
  endtask : pin_step
  // ====
  // scenarios
  task automatic t_bits();
    logic [15:0] m;
    logic [47:0] x;
    for (int r = 0; r < 3; r++)
    begin
      rd(offs[r], 16'h0, 1'b0);
      for (int b = 0; b < 16; b++)
      begin
        m = msks[r] & (16'h1 << b);
        x = PRES & ~({32'h0, m} << (16 * r));
        wr(offs[r], 32'h1 << b, 4'h3);
        rd(offs[r], m, 1'b0);
        chk("run", {16'h0, x}, {16'h0, run});
      end
      wr(offs[r], 32'h0, 4'h3);
    end
    rd(12'h00c, 16'h0, 1'b1);
    wr(12'h00c, 32'hffff, 4'hf);
    wr(ONE_OFF, 32'hffff_ffff, 4'h1);
    rd(ONE_OFF, 16'h00ff, 1'b0);
    wr(ONE_OFF, 32'h0, 4'h3);
    $display("test bits done");
  endtask : t_bits
  task automatic t_delay();
    for (int v = 0; v < 2; v++)
    begin
      wr(ONE_OFF, v ? 32'h0 : 32'h0800, 4'h3);
      #1;
      chk("run old", {63'h0, ~v[0]}, {63'h0, run[11]});
      @(posedge sys_clk);
      #1;
      chk("run new", {63'h0, v[0]}, {63'h0, run[11]});
      @(posedge sys_clk);
    end
    $display("test delay done");
  endtask : t_delay
  task automatic t_pins();
    sel1 <= 32'h0000_00ff;
    sel2 <= 32'h0000_0f0f;
    pin_step(TWO_OFF, 32'h0, 32'h0000_000f);
    pin_step(ONE_OFF, 32'h1, 32'h0000_0f0f);
    pin_step(THREE_OFF, 32'h1, 32'hffff_ffff);
    pin_step(ONE_OFF, 32'h0, 32'h0000_00ff);
    wr(THREE_OFF, 32'h0, 4'h3);
    $display("test pins done");
  endtask : t_pins
  task automatic t_gate();
    logic [7:0] a, c;
    wr(ONE_OFF, 32'h0800, 4'h3);
    repeat (3) @(posedge sys_clk);
    #1;
    a = ticks[11];
    c = ticks[12];
    repeat (10) @(posedge sys_clk);
    #1;
    chk("timer1 ticks", 64'h0, {56'h0, ticks[11] - a});
    chk("timer2 ticks", 64'ha, {56'h0, ticks[12] - c});
    @(posedge sys_clk);
    wr(ONE_OFF, 32'h0, 4'h3);
    wr(TWO_OFF, 32'hffff, 4'h3);
    rst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rd(TWO_OFF, 16'h0, 1'b0);
    chk("run", {16'h0, PRES}, {16'h0, run});
    $display("test gate done");
  endtask : t_gate
  // main sequence
  initial
  begin
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    chk("run", {16'h0, PRES}, {16'h0, run});
    t_bits();
    t_delay();
    t_pins();
    t_gate();
    wrap_up();
  end
endmodule : pmd_top_test
